/* File: design/dps_ctl.sv */
// DDR4 controller end: link clock divider, power-state sequencing, mode register writes.
//
// The address-and-strobe port and the address map were left to the implementer.
`include "dps_params.svh"
// Function
// - Device decides transitions from clock-enable sample pairs.
// - Hold new clock-enable level for minimum pulse.
// - Deselect during self-refresh exit; reads after lock.
// - Self refresh only from idle with refresh.
// - Only deselect on power-down entry and exit.
// - Self-refresh exit takes deselect, optionally no-operation.
// - Device does no refresh during power-down.
// - Device ignores command pins while powered down.
// - Termination off in self refresh, not affecting states.
// - Power-down kind chosen when command completes.
// - Idle means banks closed, no burst, timers met.
// - Controller only issues listed legal sequences.
// - Seven mode registers, written only by register set.
// - Controller writes all mode registers after reset.
// - Every register write drives all address fields.
// - Register writes leave array contents unchanged.
// - Register writes only in idle state.
// - Two register writes spaced by cycle time.
// - Input-changing writes wait for function update.
// - Only deselects within update delay after write.
// - Special-function writes use their longer delay.
// - Termination low around termination-changing register writes.
module dps_ctl
  import dps_pkg::*;
#(
  parameter int LINK_HALF = `DPS_LINK_HALF
)
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  dps_link_if.ctl          link
);
  typedef struct packed {
    dps_cstate_type     st;
    logic [2:0]         div;
    logic               ck;
    logic               cke;
    logic [4:0]         pins;
    logic               odt;
    logic [1:0]         bg;
    logic [1:0]         ba;
    logic [13:0]        addr;
    logic [7:0]         t_cke;
    logic [7:0]         t_mrd;
    logic [7:0]         t_mod;
    logic [7:0]         t_xs;
    logic [7:0]         t_dll;
    logic [7:0]         odt_low;
    logic               odt_hold;
    logic [3:0]         burst;
    logic               open;
    logic [2:0]         init_idx;
    logic               init_done;
    logic               pend;
    dps_op_type         p_op;
    logic [3:0]         p_sel;
    logic [13:0]        p_arg;
    logic               p_odtaff;
    logic               p_slow;
    logic               pd_req;
    logic               sr_req;
    logic               odt_en;
    logic               nop_exit;
    logic [6:0][13:0]   mr;
    logic [31:0]        rdata;
  } dps_ctl_st_type;

  dps_ctl_st_type r;
  dps_ctl_st_type n;

  // The three-bit divider counts one link period of 2 * LINK_HALF system clocks.
  if (LINK_HALF < 2 || LINK_HALF > 4) begin : g_half_check
    $error("LINK_HALF must lie between 2 and 4");
  end

  // Pin pattern {cs_n, act_n, ras_n, cas_n, we_n} of each issued command.
  function automatic logic [4:0] enc(input dps_cmd_type c);
    case (c)
      CMD_NOP: enc = 5'h0f;
      CMD_MRS: enc = 5'h08;
      CMD_REF: enc = 5'h09;
      CMD_PREA: enc = 5'h0a;
      CMD_ACT: enc = 5'h07;
      CMD_WR: enc = 5'h0c;
      CMD_RD: enc = 5'h0d;
      default: enc = 5'h1f;
    endcase
  endfunction

  // Counts a timer down to zero and holds it there.
  function automatic logic [7:0] dec8(input logic [7:0] x);
    dec8 = (x == 8'h00) ? 8'h00 : x - 8'h01;
  endfunction

  // Next state: divider, register port, and one command decision per link cycle.
  always_comb begin
    logic launch;
    logic quiet;
    logic idle;
    logic odt_ok;
    logic issue;
    launch = (r.div == 3'(LINK_HALF - 1));
    n = r;
    n.div = (r.div == 3'(2 * LINK_HALF - 1)) ? 3'h0 : r.div + 3'h1;
    n.ck = (n.div < 3'(LINK_HALF));
    quiet = (r.t_mod == 8'h00) && (r.t_xs == 8'h00);
    idle = !r.open && (r.burst == 4'h0) && r.cke && quiet && (r.t_cke == 8'h00);
    odt_ok = !r.p_odtaff || (r.odt_low >= `DPS_ODTLOFF + 8'h01);
    issue = 1'b0;
    // Register writes and reads; a command write is ignored while one is pending.
    if (i_wr && i_addr == `DPS_REG_CMD && !r.pend) begin
      n.pend = 1'b1;
      n.p_op = dps_op_type'(i_wdata[`DPS_CMD_OP]);
      n.p_sel = i_wdata[`DPS_CMD_SEL];
      n.p_arg = i_wdata[`DPS_CMD_ARG];
      n.p_odtaff = i_wdata[`DPS_CMD_ODTAFF];
      n.p_slow = i_wdata[`DPS_CMD_SLOW];
    end
    if (i_wr && i_addr == `DPS_REG_PWR) begin
      n.pd_req = i_wdata[`DPS_PWR_PD];
      n.sr_req = i_wdata[`DPS_PWR_SR];
      n.odt_en = i_wdata[`DPS_PWR_ODT];
      n.nop_exit = i_wdata[`DPS_PWR_NOPX];
    end
    n.rdata = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        `DPS_REG_CMD: n.rdata = {6'h00, r.p_slow, r.p_odtaff, 2'h0, r.p_arg,
                                 r.p_sel, r.pend, r.p_op};
        `DPS_REG_PWR: n.rdata = {28'h0000000, r.nop_exit, r.odt_en, r.sr_req, r.pd_req};
        `DPS_REG_STAT: n.rdata = {23'h000000, (r.burst != 4'h0), !quiet, r.open,
                                  r.cke, r.st, r.pend, r.init_done};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    if (launch) begin
      n.t_cke = dec8(r.t_cke);
      n.t_mrd = dec8(r.t_mrd);
      n.t_mod = dec8(r.t_mod);
      n.t_xs = dec8(r.t_xs);
      n.t_dll = dec8(r.t_dll);
      n.burst = (r.burst == 4'h0) ? 4'h0 : r.burst - 4'h1;
      n.odt_low = r.odt ? 8'h00 : ((r.odt_low == 8'hff) ? 8'hff : r.odt_low + 8'h01);
      n.pins = enc(CMD_DES);
      if (r.t_mod == 8'h00) begin
        n.odt_hold = 1'b0;
      end
      case (r.st)
        CS_INIT: begin
          // Every mode register is written once from its shadow after reset.
          if (r.t_mrd == 8'h00) begin
            n.pins = enc(CMD_MRS);
            n.bg = {1'b0, r.init_idx[2]};
            n.ba = r.init_idx[1:0];
            n.addr = r.mr[r.init_idx];
            n.t_mrd = `DPS_TMRD;
            n.t_mod = `DPS_TMOD;
            n.init_idx = r.init_idx + 3'h1;
            if (r.init_idx == 3'h6) begin
              n.st = CS_RUN;
              n.init_done = 1'b1;
            end
          end
        end
        CS_RUN: begin
          if (r.sr_req && idle && !r.pend) begin
            n.pins = enc(CMD_REF);
            n.cke = 1'b0;
            n.t_cke = `DPS_TCKE - 8'h01;
            n.st = CS_SR;
          end else if (r.pd_req && r.t_cke == 8'h00 && quiet) begin
            n.cke = 1'b0;
            n.t_cke = `DPS_TCKE - 8'h01;
            n.st = CS_PD;
          end else if (r.pend && quiet) begin
            case (r.p_op)
              OP_MRS: begin
                if (idle && r.t_mrd == 8'h00 && odt_ok && r.p_sel[3:0] < 4'h7) begin
                  issue = 1'b1;
                  n.pins = enc(CMD_MRS);
                  n.bg = {1'b0, r.p_sel[2]};
                  n.ba = r.p_sel[1:0];
                  n.addr = r.p_arg;
                  n.mr[r.p_sel[2:0]] = r.p_arg;
                  n.t_mrd = r.p_slow ? `DPS_TSLOW : `DPS_TMRD;
                  n.t_mod = r.p_slow ? `DPS_TSLOW : `DPS_TMOD;
                  n.odt_hold = r.p_odtaff;
                end else if (r.p_sel[3:0] >= 4'h7) begin
                  n.pend = 1'b0;
                end
              end
              OP_ACT: begin
                issue = 1'b1;
                n.pins = enc(CMD_ACT);
                n.bg = r.p_sel[3:2];
                n.ba = r.p_sel[1:0];
                n.addr = r.p_arg;
                n.open = 1'b1;
              end
              OP_PREA: begin
                issue = (r.burst == 4'h0);
                n.pins = issue ? enc(CMD_PREA) : enc(CMD_DES);
                n.addr = 14'h0400;
                n.open = issue ? 1'b0 : r.open;
              end
              OP_RD, OP_WR: begin
                issue = r.open && (r.burst == 4'h0) && (r.t_dll == 8'h00 || r.p_op == OP_WR);
                n.pins = !issue ? enc(CMD_DES) : (r.p_op == OP_RD) ? enc(CMD_RD) : enc(CMD_WR);
                n.bg = r.p_sel[3:2];
                n.ba = r.p_sel[1:0];
                n.addr = r.p_arg;
                n.burst = issue ? `DPS_BURST : n.burst;
              end
              OP_REF: begin
                issue = idle;
                n.pins = issue ? enc(CMD_REF) : enc(CMD_DES);
              end
              default: n.pend = 1'b0;
            endcase
            if (issue) begin
              n.pend = 1'b0;
            end
          end
        end
        CS_PD: begin
          if (!r.pd_req && r.t_cke == 8'h00) begin
            n.cke = 1'b1;
            n.t_cke = `DPS_TCKE - 8'h01;
            n.t_xs = `DPS_TXP;
            n.st = CS_RUN;
          end
        end
        CS_SR: begin
          if (!r.sr_req && r.t_cke == 8'h00) begin
            n.cke = 1'b1;
            n.t_cke = `DPS_TCKE - 8'h01;
            n.t_xs = `DPS_TXS;
            n.t_dll = `DPS_TXSDLL;
            n.st = CS_SRX;
          end
        end
        CS_SRX: begin
          n.pins = r.nop_exit ? enc(CMD_NOP) : enc(CMD_DES);
          if (r.t_xs == 8'h00) begin
            n.pins = enc(CMD_DES);
            n.st = CS_RUN;
          end
        end
        default: n.st = CS_INIT;
      endcase
      // Termination waits for DLL lock and drops around affecting register writes.
      n.odt = r.odt_en && (n.st == CS_RUN) && (r.t_dll == 8'h00) && !n.odt_hold
              && !(n.pend && n.p_op == OP_MRS && n.p_odtaff);
    end
  end

  // State register; reset leaves the link deselected with the clock enable high.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      r <= '0;
      r.pins <= 5'h1f;
      r.cke <= 1'b1;
      r.ck <= 1'b1;
      r.mr <= {7{`DPS_MR_RST}};
    end else begin
      r <= n;
    end
  end

  // Link pins and read data come straight from the state register.
  assign link.ck = r.ck;
  assign link.cke = r.cke;
  assign link.cs_n = r.pins[4];
  assign link.act_n = r.pins[3];
  assign link.ras_n = r.pins[2];
  assign link.cas_n = r.pins[1];
  assign link.we_n = r.pins[0];
  assign link.odt = r.odt;
  assign link.bg = r.bg;
  assign link.ba = r.ba;
  assign link.addr = r.addr;
  assign o_rdata = r.rdata;
endmodule

/* File: design/dps_dev.sv */
// DDR4 device end: power-state tracking, mode registers and link checks.
`include "dps_params.svh"
module dps_dev
  import dps_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  dps_link_if.dev         link,
  input  wire logic [2:0] i_mr_sel,
  input  wire logic       i_nop_exit_ok,
  input  wire logic       i_viol_clr,
  output logic [2:0]      o_state,
  output logic            o_idle,
  output logic            o_odt_term,
  output logic [15:0]     o_ref_count,
  output logic [13:0]     o_mr_data,
  output logic            o_viol
);
  typedef struct packed {
    dps_pins_type       s1;
    dps_pins_type       s2;
    logic               ckp;
    logic               ckeprev;
    dps_dstate_type     st;
    logic [15:0]        banks;
    logic [3:0]         burst;
    logic [7:0]         xs;
    logic [6:0][13:0]   mr;
    logic [15:0]        refs;
    logic               viol;
    logic               odt_on;
    logic [13:0]        mr_q;
  } dps_dev_st_type;

  dps_dev_st_type r;
  dps_dev_st_type n;

  // Next state: synchronise the pins, then act on each rising link clock edge.
  always_comb begin
    dps_pins_type p;
    dps_cmd_type  cmd;
    logic [3:0]   bk;
    logic         vset;
    logic         idle;
    n = r;
    p = r.s2;
    cmd = dps_decode(p);
    bk = {p.bg, p.ba};
    vset = 1'b0;
    idle = (r.st == DS_IDLE) && (r.burst == 4'h0) && (r.xs == 8'h00) && r.ckeprev;
    n.s1 = {link.ck, link.cke, link.cs_n, link.act_n, link.ras_n, link.cas_n, link.we_n,
            link.odt, link.bg, link.ba, link.addr};
    n.s2 = r.s1;
    n.ckp = r.s2.ck;
    if (r.s2.ck && !r.ckp) begin
      n.ckeprev = p.cke;
      if (r.burst != 4'h0) begin
        n.burst = r.burst - 4'h1;
      end
      if (r.xs != 8'h00) begin
        n.xs = r.xs - 8'h01;
      end
      case (r.st)
        DS_PD_PRE, DS_PD_ACT: begin
          // Commands are ignored and no refresh is counted here.
          if (r.burst == 4'h1) begin
            n.st = (r.banks == 16'h0000) ? DS_PD_PRE : DS_PD_ACT;
          end
          if (!r.ckeprev && p.cke) begin
            n.st = (r.banks != 16'h0000) ? DS_ACTIVE : DS_IDLE;
            n.xs = `DPS_TXP;
          end
        end
        DS_SREF: begin
          if (!r.ckeprev && p.cke) begin
            n.st = DS_IDLE;
            n.xs = `DPS_TXS;
          end
        end
        default: begin
          if (r.ckeprev && !p.cke) begin
            if (cmd == CMD_REF && idle) begin
              n.st = DS_SREF;
            end else begin
              vset = (cmd != CMD_DES);
              if (r.burst != 4'h0 || r.banks != 16'h0000) begin
                n.st = DS_PD_ACT;
              end else begin
                n.st = DS_PD_PRE;
              end
            end
          end else if (p.cke) begin
            if (r.xs != 8'h00 && cmd != CMD_DES && !(cmd == CMD_NOP && i_nop_exit_ok)) begin
              vset = 1'b1;
            end
            case (cmd)
              CMD_MRS: begin
                // Only mode register storage changes; no array state exists.
                if (idle && bk[2:0] != 3'h7 && bk[3] == 1'b0) begin
                  n.mr[bk[2:0]] = p.addr;
                end else begin
                  vset = 1'b1;
                end
              end
              CMD_ACT: n.banks[bk] = 1'b1;
              CMD_PRE: n.banks[bk] = 1'b0;
              CMD_PREA: n.banks = 16'h0000;
              CMD_RD, CMD_WR: n.burst = `DPS_BURST;
              CMD_REF: n.refs = r.refs + 16'h0001;
              default: n.refs = r.refs;
            endcase
            n.st = (n.banks != 16'h0000) ? DS_ACTIVE : DS_IDLE;
          end
        end
      endcase
      n.odt_on = p.odt && (n.st != DS_SREF);
    end
    // A new violation wins over a clear in the same cycle.
    if (vset) begin
      n.viol = 1'b1;
    end else if (i_viol_clr) begin
      n.viol = 1'b0;
    end
    n.mr_q = (i_mr_sel == 3'h7) ? 14'h0000 : r.mr[i_mr_sel];
  end

  // State register; link clock samples start high like the idle link, so no false edge follows.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      r <= '0;
      r.s1.ck <= 1'b1;
      r.s2.ck <= 1'b1;
      r.ckp <= 1'b1;
      r.ckeprev <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Outputs come straight from the state register.
  assign o_state = r.st;
  assign o_idle = (r.st == DS_IDLE) && (r.burst == 4'h0) && (r.xs == 8'h00) && r.ckeprev;
  assign o_odt_term = r.odt_on;
  assign o_ref_count = r.refs;
  assign o_mr_data = r.mr_q;
  assign o_viol = r.viol;
endmodule

/* File: design/dps_link_if.sv */
// Link between the memory controller and the DDR4 device model.
interface dps_link_if;
  logic        ck;
  logic        cke;
  logic        cs_n;
  logic        act_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic        odt;
  logic [1:0]  bg;
  logic [1:0]  ba;
  logic [13:0] addr;
  modport ctl (output ck, cke, cs_n, act_n, ras_n, cas_n, we_n, odt, bg, ba, addr);
  modport dev (input ck, cke, cs_n, act_n, ras_n, cas_n, we_n, odt, bg, ba, addr);
endinterface

/* File: design/dps_params.svh */
// Constants of the DDR4 power-state and mode-register link: offsets, fields, timings.
`ifndef DPS_PARAMS_SVH
`define DPS_PARAMS_SVH
// System clocks per half period of the link clock (four gives 400 ns at 10 MHz).
`define DPS_LINK_HALF 4
// Link timings, counted in link clock cycles.
`define DPS_TMRD 8'd8
`define DPS_TMOD 8'd24
`define DPS_TCKE 8'd4
`define DPS_TXP 8'd6
`define DPS_TXS 8'd12
`define DPS_TXSDLL 8'd64
`define DPS_ODTLOFF 8'd4
`define DPS_TSLOW 8'd32
`define DPS_BURST 4'd4
// Value every mode register shadow holds after reset.
`define DPS_MR_RST 14'h0000
// Controller register offsets.
`define DPS_REG_CMD 8'h00
`define DPS_REG_PWR 8'h04
`define DPS_REG_STAT 8'h08
// Command register fields.
`define DPS_CMD_OP 2:0
`define DPS_CMD_SEL 7:4
`define DPS_CMD_ARG 21:8
`define DPS_CMD_ODTAFF 24
`define DPS_CMD_SLOW 25
// Power register fields.
`define DPS_PWR_PD 0
`define DPS_PWR_SR 1
`define DPS_PWR_ODT 2
`define DPS_PWR_NOPX 3
`endif

/* File: design/dps_pkg.sv */
// Types shared by both ends of the DDR4 power-state link.
package dps_pkg;
  typedef enum logic [3:0] {
    CMD_DES  = 4'h0,
    CMD_NOP  = 4'h1,
    CMD_MRS  = 4'h2,
    CMD_REF  = 4'h3,
    CMD_PRE  = 4'h4,
    CMD_PREA = 4'h5,
    CMD_ACT  = 4'h6,
    CMD_WR   = 4'h7,
    CMD_RD   = 4'h8,
    CMD_ZQ   = 4'h9,
    CMD_RFU  = 4'ha
  } dps_cmd_type;

  typedef enum logic [2:0] {
    DS_IDLE   = 3'h0,
    DS_ACTIVE = 3'h1,
    DS_PD_PRE = 3'h2,
    DS_PD_ACT = 3'h3,
    DS_SREF   = 3'h4
  } dps_dstate_type;

  typedef enum logic [2:0] {
    CS_INIT = 3'h0,
    CS_RUN  = 3'h1,
    CS_PD   = 3'h2,
    CS_SR   = 3'h3,
    CS_SRX  = 3'h4
  } dps_cstate_type;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ACT  = 3'h1,
    OP_PREA = 3'h2,
    OP_RD   = 3'h3,
    OP_WR   = 3'h4,
    OP_REF  = 3'h5,
    OP_MRS  = 3'h6
  } dps_op_type;

  typedef struct packed {
    logic        ck;
    logic        cke;
    logic        cs_n;
    logic        act_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        odt;
    logic [1:0]  bg;
    logic [1:0]  ba;
    logic [13:0] addr;
  } dps_pins_type;

  // Decodes the command pins sampled at one rising link clock edge.
  function automatic dps_cmd_type dps_decode(input dps_pins_type p);
    dps_cmd_type c;
    c = CMD_DES;
    if (p.cs_n) begin
      c = CMD_DES;
    end else if (!p.act_n) begin
      c = CMD_ACT;
    end else begin
      case ({p.ras_n, p.cas_n, p.we_n})
        3'h0: c = CMD_MRS;
        3'h1: c = CMD_REF;
        3'h2: c = p.addr[10] ? CMD_PREA : CMD_PRE;
        3'h3: c = CMD_RFU;
        3'h4: c = CMD_WR;
        3'h5: c = CMD_RD;
        3'h6: c = CMD_ZQ;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction
endpackage

/* File: verif/dps_sva.sv */
// Checker for the link pins between the controller end and the device end.
module dps_sva #(
  parameter int LINK_HALF = 4
)
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        ck,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        act_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [13:0] addr
);
  localparam int PER = 2 * LINK_HALF;
  localparam int GAP = 3 * PER - 1;
  logic       ck_q, cke_q, cke_s, sr_r, rise, c_mrs, c_ref, c_nop, c_rd;
  logic [7:0] mod_cnt, cke_cnt, x_cnt;
  // Command decode of the pins as they stand at a rising link clock.
  assign rise = ck && !ck_q;
  assign c_mrs = !cs_n && act_n && !ras_n && !cas_n && !we_n;
  assign c_ref = !cs_n && act_n && !ras_n && !cas_n && we_n;
  assign c_nop = !cs_n && act_n && ras_n && cas_n && we_n;
  assign c_rd = !cs_n && act_n && ras_n && !cas_n && we_n;
  // Saturating counters: system clocks since a clock-enable change, link cycles since a register write and since a self-refresh exit.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ck_q <= 1'b1;
      cke_q <= 1'b1;
      cke_s <= 1'b1;
      sr_r <= 1'b0;
      mod_cnt <= 8'hff;
      cke_cnt <= 8'hff;
      x_cnt <= 8'hff;
    end else begin
      ck_q <= ck;
      cke_s <= cke;
      cke_cnt <= (cke != cke_s) ? 8'h00 : cke_cnt + {7'h0, cke_cnt != 8'hff};
      if (rise) begin
        cke_q <= cke;
        mod_cnt <= c_mrs ? 8'h00 : mod_cnt + {7'h0, mod_cnt != 8'hff};
        sr_r <= (cke_q && !cke && c_ref) || (sr_r && !cke);
        x_cnt <= (sr_r && cke) ? 8'h00 : x_cnt + {7'h0, x_cnt != 8'hff};
      end
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_next_rise;
    ##PER $rose(ck);
  endsequence
  a_link_period: assert property ($rose(ck) |-> s_next_rise)
    else $error("link clock period wrong");
  a_pins_launch: assert property ($changed({cke, cs_n, act_n, ras_n, cas_n, we_n, addr})
    |-> $fell(ck)) else $error("pins changed off launch edge");
  a_cke_gap: assert property (cke != cke_s |-> cke_cnt >= GAP)
    else $error("clock enable changed too soon");
  a_pd_entry_des: assert property (rise && cke_q && !cke |-> cs_n || c_ref)
    else $error("command at power-down entry");
  a_exit_des: assert property (rise && !cke_q && cke |-> cs_n || c_nop)
    else $error("command at exit edge");
  a_mrs_spacing: assert property (rise && c_mrs |-> mod_cnt >= 8'd7)
    else $error("register writes too close");
  a_mod_wait: assert property (rise && !cs_n && !c_mrs |-> mod_cnt >= 8'd23)
    else $error("command inside update delay");
  a_srx_des: assert property (rise && x_cnt < 8'd11 |-> cs_n || c_nop)
    else $error("command inside self-refresh exit");
  a_rd_lock: assert property (rise && c_rd |-> x_cnt >= 8'd63)
    else $error("read before lock time");
endmodule

/* File: verif/test_ddr4_cke_power_state_and_mrs_timing.sv */
// Self-checking bench joining the controller end and the device end.
`include "dps_params.svh"
module test_ddr4_cke_power_state_and_mrs_timing;
  timeunit 1ns;
  timeprecision 1ns;
  import dps_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [2:0]  mr_sel = 3'h0;
  logic        nop_ok = 1'b0;
  logic        vclr = 1'b0;
  logic [2:0]  state;
  logic        idle, term, viol;
  logic [15:0] refs, r0;
  logic [13:0] mr;
  int          err_total = 0;
  int          total_checks = 0;
  // Free-running system clock.
  always #50 clk = ~clk;
  dps_link_if dps_link_if_i ();
  dps_ctl #(.LINK_HALF(2)) dps_ctl_i (.i_sys_clk(clk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .link(dps_link_if_i));
  dps_dev dps_dev_i (.i_sys_clk(clk), .i_rst(rst), .link(dps_link_if_i), .i_mr_sel(mr_sel),
    .i_nop_exit_ok(nop_ok), .i_viol_clr(vclr), .o_state(state), .o_idle(idle),
    .o_odt_term(term), .o_ref_count(refs), .o_mr_data(mr), .o_viol(viol));
  dps_sva #(.LINK_HALF(2)) dps_sva_i (.i_sys_clk(clk), .i_rst(rst), .ck(dps_link_if_i.ck),
    .cke(dps_link_if_i.cke), .cs_n(dps_link_if_i.cs_n), .act_n(dps_link_if_i.act_n),
    .ras_n(dps_link_if_i.ras_n), .cas_n(dps_link_if_i.cas_n), .we_n(dps_link_if_i.we_n),
    .addr(dps_link_if_i.addr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // Polls one status bit until it shows the wanted level, under a bound.
  task automatic wait_stat(input int b, input logic v);
    logic [31:0] s;
    for (int n = 0; n < 3000; n++) begin
      rreg(`DPS_REG_STAT, s);
      if (s[b] === v) break;
    end
    chk(32'(s[b]), 32'(v));
  endtask
  task automatic wait_state(input dps_dstate_type e);
    for (int n = 0; n < 2000 && state !== e; n++) @(negedge clk);
    chk(32'(state), 32'(e));
  endtask
  task automatic cmd(input logic [2:0] op, input logic [3:0] sel, input logic [13:0] arg,
                     input logic [1:0] fl);
    wait_stat(1, 1'b0);
    wreg(`DPS_REG_CMD, {6'h0, fl, 2'h0, arg, sel, 1'b0, op});
    wait_stat(1, 1'b0);
    wait_stat(7, 1'b0);
    repeat (8) @(negedge clk);
  endtask
  task automatic mrchk(input logic [2:0] sel, input logic [13:0] e);
    @(posedge clk);
    mr_sel <= sel;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(32'(mr), 32'(e));
  endtask
  task automatic t_init();
    wait_stat(0, 1'b1);
    wait_stat(7, 1'b0);
    repeat (8) @(posedge clk);
    wait_state(DS_IDLE);
    chk(32'(idle), 32'h1);
    chk(32'(viol), 32'h0);
    mrchk(3'h7, 14'h0);
    $display("test init done");
  endtask
  task automatic t_mrs();
    cmd(3'h6, 4'h3, 14'h01a5, 2'h0);
    cmd(3'h6, 4'h5, 14'h02c3, 2'h3);
    cmd(3'h6, 4'h7, 14'h03ff, 2'h0);
    mrchk(3'h3, 14'h01a5);
    mrchk(3'h5, 14'h02c3);
    mrchk(3'h7, 14'h0);
    chk(32'(viol), 32'h0);
    r0 = refs;
    cmd(3'h5, 4'h0, 14'h0, 2'h0);
    chk(32'(refs), 32'(r0 + 16'h1));
    $display("test mrs done");
  endtask
  task automatic t_pd();
    logic [31:0] s;
    wreg(`DPS_REG_PWR, 32'h1);
    wait_state(DS_PD_PRE);
    rreg(`DPS_REG_STAT, s);
    chk(32'(s[5]), 32'h0);
    chk(32'(refs), 32'(r0 + 16'h1));
    wreg(`DPS_REG_PWR, 32'h0);
    wait_state(DS_IDLE);
    cmd(3'h1, 4'h1, 14'h0123, 2'h0);
    wait_state(DS_ACTIVE);
    cmd(3'h3, 4'h1, 14'h0010, 2'h0);
    cmd(3'h4, 4'h1, 14'h0018, 2'h0);
    wreg(`DPS_REG_PWR, 32'h1);
    wait_state(DS_PD_ACT);
    chk(32'(idle), 32'h0);
    wreg(`DPS_REG_PWR, 32'h0);
    wait_state(DS_ACTIVE);
    cmd(3'h2, 4'h0, 14'h0400, 2'h0);
    wait_state(DS_IDLE);
    $display("test power-down done");
  endtask
  task automatic t_sr(input logic nx, input logic ok);
    wreg(`DPS_REG_PWR, 32'h4);
    nop_ok <= ok;
    repeat (40) @(negedge clk);
    chk(32'(term), 32'h1);
    wreg(`DPS_REG_PWR, {28'h0, nx, 3'h6});
    wait_state(DS_SREF);
    chk(32'(term), 32'h0);
    wreg(`DPS_REG_PWR, {28'h0, nx, 3'h4});
    wait_state(DS_IDLE);
    cmd(3'h1, 4'h2, 14'h0040, 2'h0);
    cmd(3'h3, 4'h2, 14'h0008, 2'h0);
    cmd(3'h2, 4'h0, 14'h0400, 2'h0);
    repeat (300) @(negedge clk);
    chk(32'(viol), 32'(nx && !ok));
    @(posedge clk);
    vclr <= 1'b1;
    @(posedge clk);
    vclr <= 1'b0;
    repeat (4) @(negedge clk);
    chk(32'(viol), 32'h0);
    wreg(`DPS_REG_PWR, 32'h0);
    $display("test self refresh done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_init();
    t_mrs();
    t_pd();
    t_sr(1'b0, 1'b0);
    t_sr(1'b1, 1'b0);
    t_sr(1'b1, 1'b1);
    conclude();
  end
  // Watchdog against a hang.
  initial begin
    #4000000;
    err_total++;
    conclude();
  end
endmodule
